// *** verilog/dpc_regs.svh ***
// How it works
// [R1] Listed pixels get a mode-chosen value (neighbour mean, full scale or zero), not the sensor value.
// [R2] One enable bit turns list correction on; off passes every pixel.
// [R3] Average mode outputs the mean of the left and right neighbours.
// [R4] Highlight mode outputs full scale so the pixel stands out.
// [R5] The entry count limits which list entries take part.
// [R6] Entry index is zero based; software keeps it below the count.
// [R7] X and Y fields access the entry chosen by the index.
// [R8] Coordinates are full-sensor: window offsets are added before compare.
// [R9] Edits touch the staged list; the datapath keeps the active list.
// [R10] Apply copies the staged list into the volatile active list.
// [R11] Save writes persistent storage; it is loaded as active at boot.
// [R12] Factory restore overwrites active and persistent lists with defaults.
// [R13] Copies run one entry per cycle; streaming frames may look partial.
// [R14] Software adds entries: count up, index to last, coords, apply.
// [R15] Coordinate access with index at or above count flags an error.
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// Register byte offsets
`define DPC_CTRL_OFS 8'h00
`define DPC_COUNT_OFS 8'h04
`define DPC_INDEX_OFS 8'h08
`define DPC_COORD_X_OFS 8'h0C
`define DPC_COORD_Y_OFS 8'h10
`define DPC_CMD_OFS 8'h14
`define DPC_STATUS_OFS 8'h18

// Field positions
`define DPC_CTRL_EN_BIT 0
`define DPC_CTRL_MODE_LSB 1
`define DPC_CMD_APPLY_BIT 0
`define DPC_CMD_SAVE_BIT 1
`define DPC_CMD_RESTORE_BIT 2
`define DPC_STAT_BUSY_BIT 0
`define DPC_STAT_ERR_BIT 1
`define DPC_STAT_ACNT_LSB 8

// Reset values
`define DPC_CTRL_EN_RST 1'b0
`define DPC_COUNT_RST 5'h00
`define DPC_INDEX_RST 5'h00

// Sizes
`define DPC_MAX_ENTRIES 16
`define DPC_PIX_W 12
`define DPC_COORD_W 12
`define DPC_FIFO_DEPTH 8

`endif

// *** verilog/dpc_pkg.sv ***
package dpc_pkg;

   // Replacement method for listed pixels
   typedef enum logic [1:0]
   {
      MODE_AVG = 2'b00,
      MODE_HIGHLIGHT = 2'b01,
      MODE_ZERO = 2'b10
   } mode_t;

   // Table copy sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_BOOT = 3'b001,
      ST_APPLY = 3'b010,
      ST_SAVE = 3'b011,
      ST_RESTORE = 3'b100
   } copy_state_t;

endpackage

// *** verilog/pixel_fifo.sv ***
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic rdy_reg, rdy_next;
   logic push, pop;

   // Ready is registered so the source sees a clean flop
   always_comb
   begin
      push = in_valid_i && rdy_reg;
      pop = out_valid_o && out_ready_i;
      wr_next = push ? wr_reg + 1'b1 : wr_reg;
      rd_next = pop ? rd_reg + 1'b1 : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      rdy_next = cnt_next != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         rdy_reg <= 1'b0;
      end
      else
      begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         rdy_reg <= rdy_next;
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk_i)
   begin
      if (push)
         mem[wr_reg] <= in_data_i;
   end

   assign in_ready_o = rdy_reg;
   assign out_valid_o = cnt_reg != '0;
   assign out_data_o = mem[rd_reg];
endmodule

// *** verilog/defect_pixel_correction.sv ***
`timescale 1ns/1ps
`include "dpc_regs.svh"
module defect_pixel_correction #(
   parameter logic [4:0] FACTORY_COUNT = 5'h00,
   parameter logic [191:0] FACTORY_X = '0,
   parameter logic [191:0] FACTORY_Y = '0
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [11:0] offset_x_i,
   input wire logic [11:0] offset_y_i,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic [11:0] pix_data_i,
   input wire logic pix_sof_i,
   input wire logic pix_eol_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [11:0] out_data_o,
   output logic out_sof_o,
   output logic out_eol_o
);
   localparam int N = `DPC_MAX_ENTRIES;
   localparam int PW = `DPC_PIX_W;
   localparam int CW = `DPC_COORD_W;

   // Bus side state
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic en_reg, en_next;
   dpc_pkg::mode_t mode_reg, mode_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [4:0] idx_reg, idx_next;
   logic err_reg, err_next;
   logic [2:0] cmd_reg, cmd_next;
   logic req, wr, rd, idx_ok, wr_x, wr_y;
   logic [31:0] wmask, wval;

   // Copy sequencer state
   dpc_pkg::copy_state_t state_reg, state_next;
   logic [3:0] step_reg, step_next;
   logic [4:0] act_cnt_reg, act_cnt_next;
   logic [4:0] per_cnt_reg, per_cnt_next;
   logic last_step;

   // Tables: staged, active, persistent
   logic [CW-1:0] st_x [N];
   logic [CW-1:0] st_y [N];
   logic [CW-1:0] ac_x [N];
   logic [CW-1:0] ac_y [N];
   logic [CW-1:0] pe_x [N];
   logic [CW-1:0] pe_y [N];

   // Datapath state
   logic f_valid, f_ready;
   logic [PW+1:0] f_data;
   logic [CW-1:0] x_reg, x_next, y_reg, y_next;
   logic h_valid_reg, h_valid_next, h_eol_reg, h_eol_next;
   logic h_sof_reg, h_sof_next, h_def_reg, h_def_next;
   logic [PW-1:0] h_pix_reg, h_pix_next, l_pix_reg, l_pix_next;
   logic l_valid_reg, l_valid_next;
   logic o_valid_reg, o_valid_next, o_sof_reg, o_sof_next;
   logic o_eol_reg, o_eol_next;
   logic [PW-1:0] o_pix_reg, o_pix_next;
   logic [CW-1:0] cur_x, cur_y, full_x, full_y;
   logic [N-1:0] hit;
   logic pop, emit, out_free;
   logic [PW:0] sum;
   logic [PW-1:0] fixed;

   // Byte-lane merge for register writes
   always_comb
   begin
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wval = wb_dat_i & wmask;
      req = wb_cyc_i && wb_stb_i && !ack_reg;
      wr = req && wb_we_i;
      rd = req && !wb_we_i;
      idx_ok = idx_reg < cnt_reg;
      // [R15] Out of range refused
      wr_x = wr && (wb_adr_i == `DPC_COORD_X_OFS) && idx_ok;
      wr_y = wr && (wb_adr_i == `DPC_COORD_Y_OFS) && idx_ok;
   end

   // Register file next values, one-cycle ack
   always_comb
   begin
      ack_next = req;
      dat_next = 32'h0000_0000;
      en_next = en_reg;
      mode_next = mode_reg;
      cnt_next = cnt_reg;
      idx_next = idx_reg;
      err_next = err_reg;
      cmd_next = 3'h0;
      if (wr && (wb_adr_i == `DPC_CTRL_OFS))
      begin
         // [R2] Enable switch
         en_next = wb_sel_i[0] ? wb_dat_i[`DPC_CTRL_EN_BIT] : en_reg;
         if (wb_sel_i[0])
            mode_next = dpc_pkg::mode_t'(wb_dat_i[`DPC_CTRL_MODE_LSB +: 2]);
      end
      else if (wr && (wb_adr_i == `DPC_COUNT_OFS))
      begin
         // [R5] Count clamped to table size
         if (wval > 32'(N))
            cnt_next = 5'(N);
         else
            cnt_next = wval[4:0];
      end
      else if (wr && (wb_adr_i == `DPC_INDEX_OFS))
         idx_next = wval[4:0];
      else if (wr && (wb_adr_i == `DPC_CMD_OFS) &&
               (state_reg == dpc_pkg::ST_IDLE))
         cmd_next = wval[2:0];
      // [R6] Index checked against count
      else if (req && !idx_ok && ((wb_adr_i == `DPC_COORD_X_OFS) ||
               (wb_adr_i == `DPC_COORD_Y_OFS)))
         err_next = 1'b1;
      else if (wr && (wb_adr_i == `DPC_STATUS_OFS) &&
               wval[`DPC_STAT_ERR_BIT])
         err_next = 1'b0;
      if (rd)
      begin
         if (wb_adr_i == `DPC_CTRL_OFS)
            dat_next = {29'h0, mode_reg, en_reg};
         else if (wb_adr_i == `DPC_COUNT_OFS)
            dat_next = {27'h0, cnt_reg};
         else if (wb_adr_i == `DPC_INDEX_OFS)
            dat_next = {27'h0, idx_reg};
         // [R7] Coordinate read of selected entry
         else if (wb_adr_i == `DPC_COORD_X_OFS && idx_ok)
            dat_next = {20'h0, st_x[idx_reg[3:0]]};
         else if (wb_adr_i == `DPC_COORD_Y_OFS && idx_ok)
            dat_next = {20'h0, st_y[idx_reg[3:0]]};
         else if (wb_adr_i == `DPC_STATUS_OFS)
            dat_next = {19'h0, act_cnt_reg, 6'h0, err_reg,
                        state_reg != dpc_pkg::ST_IDLE};
      end
      // Sequencer loads the staged count when it rewrites that list
      if (last_step && state_reg == dpc_pkg::ST_BOOT)
         cnt_next = per_cnt_reg;
      else if (last_step && state_reg == dpc_pkg::ST_RESTORE)
         cnt_next = FACTORY_COUNT;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
         en_reg <= `DPC_CTRL_EN_RST;
         mode_reg <= dpc_pkg::MODE_AVG;
         cnt_reg <= `DPC_COUNT_RST;
         idx_reg <= `DPC_INDEX_RST;
         err_reg <= 1'b0;
         cmd_reg <= 3'h0;
      end
      else
      begin
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         en_reg <= en_next;
         mode_reg <= mode_next;
         cnt_reg <= cnt_next;
         idx_reg <= idx_next;
         err_reg <= err_next;
         cmd_reg <= cmd_next;
      end
   end

   // Sequencer: one table entry per cycle, apply wins over save
   always_comb
   begin
      last_step = step_reg == 4'(N - 1);
      state_next = state_reg;
      step_next = 4'h0;
      act_cnt_next = act_cnt_reg;
      per_cnt_next = per_cnt_reg;
      case (state_reg)
         dpc_pkg::ST_IDLE:
         begin
            // [R9] Active list changes only on command or at boot after reset
            if (cmd_reg[`DPC_CMD_APPLY_BIT])
               state_next = dpc_pkg::ST_APPLY;
            else if (cmd_reg[`DPC_CMD_SAVE_BIT])
               state_next = dpc_pkg::ST_SAVE;
            else if (cmd_reg[`DPC_CMD_RESTORE_BIT])
               state_next = dpc_pkg::ST_RESTORE;
         end
         default:
         begin
            // [R13] Transfer spreads over cycles
            step_next = step_reg + 4'h1;
            if (last_step)
            begin
               state_next = dpc_pkg::ST_IDLE;
               step_next = 4'h0;
               // [R10] Apply sets the active count
               if (state_reg == dpc_pkg::ST_APPLY)
                  act_cnt_next = cnt_reg;
               else if (state_reg == dpc_pkg::ST_SAVE)
                  per_cnt_next = cnt_reg;
               else if (state_reg == dpc_pkg::ST_BOOT)
                  act_cnt_next = per_cnt_reg;
               else
               begin
                  act_cnt_next = FACTORY_COUNT;
                  per_cnt_next = FACTORY_COUNT;
               end
            end
         end
      endcase
   end

   // Reset boots from persistent storage, which rst_i leaves alone; power-on reloads it with the factory list
   always_ff @(posedge clk_i)
   begin
      if (rst_i || por_i)
      begin
         state_reg <= dpc_pkg::ST_BOOT;
         step_reg <= 4'h0;
         act_cnt_reg <= 5'h00;
      end
      else
      begin
         state_reg <= state_next;
         step_reg <= step_next;
         act_cnt_reg <= act_cnt_next;
      end
      per_cnt_reg <= por_i ? FACTORY_COUNT : per_cnt_next;
   end

   // Per-entry table storage and copy paths
   for (genvar i = 0; i < N; i++)
   begin : g_entry
      logic [CW-1:0] sx_n, sy_n, ax_n, ay_n, px_n, py_n;
      logic [CW-1:0] fx, fy;
      logic at;
      always_comb
      begin
         fx = FACTORY_X[i*CW +: CW];
         fy = FACTORY_Y[i*CW +: CW];
         at = step_reg == 4'(i);
         sx_n = st_x[i];
         sy_n = st_y[i];
         ax_n = ac_x[i];
         ay_n = ac_y[i];
         px_n = pe_x[i];
         py_n = pe_y[i];
         // [R7] Write selected staged entry
         if (wr_x && idx_reg == 5'(i))
            sx_n = wb_dat_i[CW-1:0];
         if (wr_y && idx_reg == 5'(i))
            sy_n = wb_dat_i[CW-1:0];
         if (at && state_reg == dpc_pkg::ST_APPLY)
         begin
            // [R10] Staged to active
            ax_n = st_x[i];
            ay_n = st_y[i];
         end
         else if (at && state_reg == dpc_pkg::ST_SAVE)
         begin
            // [R11] Staged to persistent
            px_n = st_x[i];
            py_n = st_y[i];
         end
         else if (at && state_reg == dpc_pkg::ST_BOOT)
         begin
            // [R11] Persistent loaded at boot
            sx_n = pe_x[i];
            sy_n = pe_y[i];
            ax_n = pe_x[i];
            ay_n = pe_y[i];
         end
         else if (at && state_reg == dpc_pkg::ST_RESTORE)
         begin
            // [R12] Factory list everywhere
            sx_n = fx;
            sy_n = fy;
            ax_n = fx;
            ay_n = fy;
            px_n = fx;
            py_n = fy;
         end
      end
      always_ff @(posedge clk_i)
      begin
         st_x[i] <= sx_n;
         st_y[i] <= sy_n;
         ac_x[i] <= ax_n;
         ac_y[i] <= ay_n;
         pe_x[i] <= por_i ? fx : px_n;
         pe_y[i] <= por_i ? fy : py_n;
      end
      // [R5] Only counted entries match
      assign hit[i] = (5'(i) < act_cnt_reg) && (ac_x[i] == full_x) &&
                      (ac_y[i] == full_y);
   end

   // Input buffer absorbs stalls from the output side
   pixel_fifo #(
      .WIDTH(PW + 2),
      .DEPTH(`DPC_FIFO_DEPTH)
   ) pixel_fifo_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i({pix_sof_i, pix_eol_i, pix_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data)
   );

   // Position tracking and neighbour window
   always_comb
   begin
      out_free = !o_valid_reg || out_ready_i;
      // A pixel waits for its right neighbour unless it ends a line
      emit = h_valid_reg && out_free && (h_eol_reg || f_valid);
      pop = f_valid && (!h_valid_reg || emit);
      f_ready = pop;
      cur_x = f_data[PW+1] ? '0 : x_reg;
      cur_y = f_data[PW+1] ? '0 : y_reg;
      // [R8] Full-sensor coordinates
      full_x = cur_x + offset_x_i;
      full_y = cur_y + offset_y_i;
      x_next = x_reg;
      y_next = y_reg;
      h_valid_next = h_valid_reg;
      h_pix_next = h_pix_reg;
      h_eol_next = h_eol_reg;
      h_sof_next = h_sof_reg;
      h_def_next = h_def_reg;
      l_pix_next = l_pix_reg;
      l_valid_next = l_valid_reg;
      if (emit)
      begin
         h_valid_next = 1'b0;
         l_pix_next = h_pix_reg;
         l_valid_next = !h_eol_reg;
      end
      if (pop)
      begin
         h_valid_next = 1'b1;
         h_pix_next = f_data[PW-1:0];
         h_eol_next = f_data[PW];
         h_sof_next = f_data[PW+1];
         // [R1] Lookup against active list
         h_def_next = |hit;
         x_next = f_data[PW] ? '0 : cur_x + 1'b1;
         y_next = f_data[PW] ? cur_y + 1'b1 : cur_y;
         if (f_data[PW+1])
            l_valid_next = 1'b0;
      end
   end

   // Replacement value; edge pixels use their one neighbour
   always_comb
   begin
      sum = {1'b0, l_pix_reg} + {1'b0, f_data[PW-1:0]};
      // [R3] Neighbour mean
      if (l_valid_reg && !h_eol_reg)
         fixed = sum[PW:1];
      else if (l_valid_reg)
         fixed = l_pix_reg;
      else if (!h_eol_reg)
         fixed = f_data[PW-1:0];
      else
         fixed = h_pix_reg;
      // [R4] Full scale highlight
      if (mode_reg == dpc_pkg::MODE_HIGHLIGHT)
         fixed = '1;
      else if (mode_reg == dpc_pkg::MODE_ZERO)
         fixed = '0;
      o_valid_next = o_valid_reg && !out_ready_i;
      o_pix_next = o_pix_reg;
      o_sof_next = o_sof_reg;
      o_eol_next = o_eol_reg;
      if (emit)
      begin
         o_valid_next = 1'b1;
         // [R2] Bypass when disabled
         o_pix_next = (en_reg && h_def_reg) ? fixed : h_pix_reg;
         o_sof_next = h_sof_reg;
         o_eol_next = h_eol_reg;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         x_reg <= '0;
         y_reg <= '0;
         h_valid_reg <= 1'b0;
         h_pix_reg <= '0;
         h_eol_reg <= 1'b0;
         h_sof_reg <= 1'b0;
         h_def_reg <= 1'b0;
         l_pix_reg <= '0;
         l_valid_reg <= 1'b0;
         o_valid_reg <= 1'b0;
         o_pix_reg <= '0;
         o_sof_reg <= 1'b0;
         o_eol_reg <= 1'b0;
      end
      else
      begin
         x_reg <= x_next;
         y_reg <= y_next;
         h_valid_reg <= h_valid_next;
         h_pix_reg <= h_pix_next;
         h_eol_reg <= h_eol_next;
         h_sof_reg <= h_sof_next;
         h_def_reg <= h_def_next;
         l_pix_reg <= l_pix_next;
         l_valid_reg <= l_valid_next;
         o_valid_reg <= o_valid_next;
         o_pix_reg <= o_pix_next;
         o_sof_reg <= o_sof_next;
         o_eol_reg <= o_eol_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign out_valid_o = o_valid_reg;
   assign out_data_o = o_pix_reg;
   assign out_sof_o = o_sof_reg;
   assign out_eol_o = o_eol_reg;
endmodule

// *** sim/defect_pixel_correction_asserts.sv ***
`timescale 1ns/1ps
module defect_pixel_correction_asserts (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic por_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic pix_ready_o,
   input wire logic out_valid_o,
   input wire logic out_ready_i,
   input wire logic [11:0] out_data_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || por_i);

   // Bus request not yet answered, and its read form
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd_s;
      req_s ##0 !wb_we_i;
   endsequence

   // Bus handshake: one answer per request, one cycle late
   ack_timely_a: assert property (req_s |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   // Holes in the map and the command word read back as zero
   unmapped_zero_a: assert property (
      rd_s ##0 (wb_adr_i >= 8'h1C) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   cmd_zero_a: assert property (
      rd_s ##0 (wb_adr_i == 8'h14) |=> wb_dat_o == 32'h0)
      else $error("command register read not zero");
   // A stalled output pixel must not change under the consumer
   out_hold_a: assert property (
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
      else $error("output pixel dropped while stalled");
   // Quiet outputs right after reset, boot copy still pending
   rst_quiet_a: assert property (
      $fell(rst_i) |-> !wb_ack_o && !out_valid_o && !pix_ready_o)
      else $error("outputs active right after reset");
endmodule

bind defect_pixel_correction defect_pixel_correction_asserts
   defect_pixel_correction_asserts_inst (.clk_i, .rst_i, .por_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
   .pix_ready_o, .out_valid_o, .out_ready_i, .out_data_o);

// *** sim/tb_defect_pixel_correction.sv ***
`timescale 1ns/1ps
`include "dpc_regs.svh"
module tb_defect_pixel_correction;
   localparam int LEN = 16;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic por_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, pix_ready_o, out_valid_o, out_sof_o, out_eol_o;
   logic [11:0] offset_x_i = 12'h000, offset_y_i = 12'h000;
   logic pix_valid_i = 1'b0, pix_sof_i = 1'b0, pix_eol_i = 1'b0;
   logic [11:0] pix_data_i = 12'h000, out_data_o;
   logic out_ready_i = 1'b1;
   logic [11:0] got[$];
   logic [11:0] mexp[4] = '{12'h050, 12'hFFF, 12'h000, 12'h050};
   logic saw_full = 1'b0;
   int miscompares = 0, num_checks = 0, cycles = 0;

   // Factory list holds one entry at (5,0)
   defect_pixel_correction #(.FACTORY_COUNT(5'h01),
      .FACTORY_X(192'h5), .FACTORY_Y(192'h0)) defect_pixel_correction_inst (
      .clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .offset_x_i, .offset_y_i,
      .pix_valid_i, .pix_ready_o, .pix_data_i, .pix_sof_i, .pix_eol_i,
      .out_valid_o, .out_ready_i, .out_data_o, .out_sof_o, .out_eol_o);

   // Clock, 100 ns period
   always #50 clk_i = ~clk_i;

   // Collect pixels taken by the consumer and check their framing flags
   always @(posedge clk_i)
      if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      begin
         chk(32'(out_sof_o), 32'(got.size() == 0), "sof flag");
         chk(32'(out_eol_o), 32'(got.size() == LEN - 1), "eol flag");
         got.push_back(out_data_o);
      end

   // Hang guard, well above the several hundred cycles the tests need
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         miscompares++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   // One classic cycle; request held until ack is sampled
   task automatic wb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk(wb_ack_o, 1'b1, "bus ack missing");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input string m);
      logic [31:0] q;
      wb(a, 1'b0, 32'h0, q);
      chk(q, e, m);
   endtask

   // Busy shows two edges after a command, so let those pass
   task automatic wait_idle();
      logic [31:0] q;
      repeat (3) @(posedge clk_i);
      for (int n = 0; n < 40; n++)
      begin
         wb(`DPC_STATUS_OFS, 1'b0, 32'h0, q);
         if (q[0] === 1'b0)
            break;
      end
      chk(q[0], 1'b0, "sequencer stuck busy");
   endtask

   task automatic pulse_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_idle();
   endtask

   // Ramp line; pixel 5 is dark so a replacement stands out
   function automatic logic [11:0] px(input int i);
      return (i == 5) ? 12'h000 : 12'(i * 16);
   endfunction

   task automatic run_line();
      int n;
      got.delete();
      @(posedge clk_i);
      for (int i = 0; i < LEN; i++)
      begin
         pix_valid_i <= 1'b1;
         pix_data_i <= px(i);
         pix_sof_i <= (i == 0);
         pix_eol_i <= (i == LEN - 1);
         do
         begin
            @(posedge clk_i);
            if (pix_ready_o !== 1'b1)
               saw_full = 1'b1;
         end
         while (pix_ready_o !== 1'b1);
      end
      pix_valid_i <= 1'b0;
      pix_eol_i <= 1'b0;
      n = 0;
      while (got.size() < LEN && n < 200)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // Whole line against the ramp, with up to two replaced places
   task automatic chk_line(input int h1, input int h2, input logic [11:0] v,
                           input string m);
      for (int i = 0; i < LEN; i++)
         chk(got[i], (i == h1 || i == h2) ? v : px(i), m);
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      wait_idle();
      rd_chk(`DPC_CTRL_OFS, 32'h0, "ctrl reset");
      rd_chk(`DPC_COUNT_OFS, 32'h1, "boot count");
      rd_chk(`DPC_STATUS_OFS, 32'h100, "boot active count");
      rd_chk(`DPC_COORD_X_OFS, 32'h5, "factory x");
      wr(8'h1C, 32'hFFFFFFFF);
      rd_chk(8'h1C, 32'h0, "unmapped read");
      rd_chk(`DPC_CMD_OFS, 32'h0, "cmd read");
      $display("test registers done");
      // Stall the consumer so the buffer fills and refuses
      out_ready_i <= 1'b0;
      fork
         run_line();
         begin
            repeat (40) @(posedge clk_i);
            out_ready_i <= 1'b1;
         end
      join
      chk(saw_full, 1'b1, "buffer never refused");
      chk_line(-1, -1, 12'h000, "pass through");
      $display("test fill done");
      for (int m = 0; m < 4; m++)
      begin
         wr(`DPC_CTRL_OFS, 32'(1 + 2 * m));
         run_line();
         chk_line(5, 5, mexp[m], "mode replace");
      end
      $display("test modes done");
      // Highlight from here on, so every replacement reads full scale
      wr(`DPC_CTRL_OFS, 32'h3);
      offset_x_i <= 12'h002;
      run_line();
      chk_line(3, 3, 12'hFFF, "window offset");
      offset_x_i <= 12'h000;
      offset_y_i <= 12'h001;
      run_line();
      chk_line(-1, -1, 12'h000, "window offset y");
      offset_y_i <= 12'h000;
      $display("test offset done");
      wr(`DPC_COUNT_OFS, 32'h2);
      wr(`DPC_INDEX_OFS, 32'h1);
      wr(`DPC_COORD_X_OFS, 32'h8);
      wr(`DPC_COORD_Y_OFS, 32'h0);
      rd_chk(`DPC_COORD_X_OFS, 32'h8, "staged x");
      run_line();
      chk_line(5, 5, 12'hFFF, "staged edit leaked");
      wr(`DPC_CMD_OFS, 32'h1);
      wait_idle();
      rd_chk(`DPC_STATUS_OFS, 32'h200, "apply count");
      run_line();
      chk_line(5, 8, 12'hFFF, "apply");
      $display("test apply done");
      wr(`DPC_INDEX_OFS, 32'h2);
      rd_chk(`DPC_COORD_X_OFS, 32'h0, "bad index read");
      wr(`DPC_COORD_X_OFS, 32'h9);
      rd_chk(`DPC_STATUS_OFS, 32'h202, "index error");
      wr(`DPC_STATUS_OFS, 32'h2);
      rd_chk(`DPC_STATUS_OFS, 32'h200, "error clear");
      wr(`DPC_INDEX_OFS, 32'h1);
      rd_chk(`DPC_COORD_X_OFS, 32'h8, "entry kept");
      wr(`DPC_COUNT_OFS, 32'h14);
      rd_chk(`DPC_COUNT_OFS, 32'h10, "count clamp");
      wr(`DPC_COUNT_OFS, 32'h1);
      wr(`DPC_CMD_OFS, 32'h1);
      wait_idle();
      run_line();
      chk_line(5, 5, 12'hFFF, "count limit");
      $display("test index done");
      wr(`DPC_COUNT_OFS, 32'h2);
      wr(`DPC_CMD_OFS, 32'h2);
      wait_idle();
      pulse_reset();
      rd_chk(`DPC_STATUS_OFS, 32'h200, "saved list booted");
      wr(`DPC_CTRL_OFS, 32'h3);
      run_line();
      chk_line(5, 8, 12'hFFF, "saved list used");
      $display("test save done");
      wr(`DPC_CMD_OFS, 32'h4);
      wait_idle();
      rd_chk(`DPC_STATUS_OFS, 32'h100, "restore active");
      rd_chk(`DPC_COUNT_OFS, 32'h1, "restore staged");
      pulse_reset();
      rd_chk(`DPC_STATUS_OFS, 32'h100, "restore persistent");
      $display("test restore done");
      conclude();
   end
endmodule
